/* File: tpw_regs.svh */
// constants for the triple pot two-wire slave
// How it works
// - every wiper starts at position 127, maximum resistance, until first written.
// - wiper writes take effect only while write_protect is low; high locks them.
// - device address is 101000, then the strap level, then the direction bit.
// - direction bit one starts a read, zero starts a write.
// - address byte follows a start and shifts in most significant bit first.
// - matching address is acknowledged low; a mismatch stays silent and returns to standby.
// - every matching device address, memory address and data byte is acknowledged low on the ninth clock.
// - data falling while clock high is a start; it must precede every command.
// - data rising while clock high is a stop; it returns the device to standby.
// - data changes only while clock low; changes during clock high are start or stop.
// - standby after power-on, after a stop, and after internal operations finish.
// - after a write address, the memory address byte follows and is acknowledged.
// - a data byte follows and is acknowledged; a stop ends the write.
// - the timed nonvolatile store begins only at the stop condition.
// - address F8h selects the 90k wiper, F9h the first 10k, FAh the second.
// - wipers keep only the low seven bits of a written byte.
// - during the timed store all bus inputs are ignored and nothing is acknowledged.
// - up to eight data bytes per write, address wrapping inside the page.
`ifndef TPW_REGS_SVH
`define TPW_REGS_SVH
`define TPW_DEV_FIXED 6'h28
`define TPW_ADDR_WIPER_90K 8'hF8
`define TPW_ADDR_WIPER_10K_A 8'hF9
`define TPW_ADDR_WIPER_10K_B 8'hFA
`define TPW_WIPER_DEFAULT 7'h7F
`define TPW_LAST_BIT 3'h7
`define TPW_PAGE_BYTES 8
`define TPW_SYNC_RESET 4'hF
`define TPW_STORE_TIME_US 10000
`define TPW_CLK_MHZ 125
`endif

/* File: tpw_pkg.sv */
// types shared by the two-wire slave modules
package tpw_pkg;
   typedef enum logic [3:0] {
      TPW_IDLE, TPW_DEV_ADDR, TPW_MEM_ADDR, TPW_WR_DATA, TPW_ACK_WAIT, TPW_ACK,
      TPW_RD_DATA, TPW_RD_WAIT, TPW_RD_ACK, TPW_RD_LOAD, TPW_IGNORE
   } tpw_state_t;
   typedef enum logic [1:0] {TPW_SEL_90K, TPW_SEL_10K_A, TPW_SEL_10K_B, TPW_SEL_NONE} tpw_sel_t;
endpackage : tpw_pkg

/* File: tpw_pin_sync.sv */
// three-stage pin synchroniser that updates once stages two and three agree
`timescale 1ns/1ps
`include "tpw_regs.svh"
module tpw_pin_sync
   import tpw_pkg::*;
#(
   parameter int W = 4
)(
   input wire logic clk, // system clock
   input wire logic sys_rst, // synchronous reset
   input wire logic [W-1:0] pin_in, // asynchronous pins
   output logic [W-1:0] pin_out // filtered levels
);
   logic [W-1:0] ff1, ff2, ff3, next_out;

   always_comb
   begin
      for (int i = 0; i < W; i++)
      begin
         next_out[i] = (ff2[i] == ff3[i]) ? ff3[i] : pin_out[i];
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ff1 <= W'(`TPW_SYNC_RESET);
         ff2 <= W'(`TPW_SYNC_RESET);
         ff3 <= W'(`TPW_SYNC_RESET);
         pin_out <= W'(`TPW_SYNC_RESET);
      end
      else
      begin
         ff1 <= pin_in;
         ff2 <= ff1;
         ff3 <= ff2;
         pin_out <= next_out;
      end
   end
endmodule : tpw_pin_sync

/* File: tpw_nv_timer.sv */
// nonvolatile store timer: busy for a fixed number of cycles after a start pulse
`timescale 1ns/1ps
module tpw_nv_timer
   import tpw_pkg::*;
#(
   parameter int CYCLES = 1250000
)(
   input wire logic clk, // system clock
   input wire logic sys_rst, // synchronous reset
   input wire logic start, // one-cycle store request
   output logic busy // store in progress
);
   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] cnt, next_cnt;
   logic next_busy;

   always_comb
   begin
      if (start)
         next_cnt = CW'(CYCLES);
      else if (cnt != '0)
         next_cnt = cnt - CW'(1);
      else
         next_cnt = '0;
      next_busy = (next_cnt != '0);
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cnt <= '0;
         busy <= 1'b0;
      end
      else
      begin
         cnt <= next_cnt;
         busy <= next_busy;
      end
   end
endmodule : tpw_nv_timer

/* File: tpw_slave.sv */
// two-wire slave with three wiper registers, page buffer and timed store
`timescale 1ns/1ps
`include "tpw_regs.svh"
module tpw_slave
   import tpw_pkg::*;
#(
   parameter int STORE_CYCLES = `TPW_STORE_TIME_US * `TPW_CLK_MHZ
)(
   input wire logic clk, // system clock, 125 MHz
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic scl_in, // serial clock pin level
   input wire logic sda_in, // serial data pin level
   input wire logic address_select_strap, // address select strap
   input wire logic write_protect, // high locks the wipers
   output logic sda_out, // data pin drive value, always low
   output logic sda_oe, // high while pulling data low
   output logic [6:0] wiper_90k, // 90k wiper position
   output logic [6:0] wiper_10k_a, // first 10k wiper position
   output logic [6:0] wiper_10k_b, // second 10k wiper position
   output logic store_busy, // timed store in progress
   output logic standby // low-power state
);
   logic [3:0] pins;
   logic scl_s, sda_s, wp_s, strap_s, scl_q, sda_q;
   logic scl_rise, scl_fall, start_ev, stop_ev, store_go;
   tpw_state_t state, next_state, after, next_after;
   logic [2:0] cnt, next_cnt;
   logic [7:0] shift, next_shift, tx, next_tx, mem_addr, next_mem, rx_byte;
   logic [7:0][7:0] pdata, next_pdata;
   logic [7:0] pvalid, next_pvalid;
   logic [2:0][6:0] wiper, next_wiper;
   logic next_oe, next_standby;
   logic [7:0] ca;
   tpw_sel_t cs;

   tpw_pin_sync #(.W(4)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin_in({address_select_strap, write_protect, sda_in, scl_in}),
      .pin_out(pins)
   );

   tpw_nv_timer #(.CYCLES(STORE_CYCLES)) u_timer (
      .clk(clk),
      .sys_rst(sys_rst),
      .start(store_go),
      .busy(store_busy)
   );

   assign scl_s = pins[0];
   assign sda_s = pins[1];
   assign wp_s = pins[2];
   assign strap_s = pins[3];
   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_ev = scl_s & scl_q & ~sda_q & sda_s;
   assign wiper_90k = wiper[TPW_SEL_90K];
   assign wiper_10k_a = wiper[TPW_SEL_10K_A];
   assign wiper_10k_b = wiper[TPW_SEL_10K_B];

   // map a memory address onto a wiper
   function automatic tpw_sel_t wiper_sel(input logic [7:0] a);
      unique case (a)
         `TPW_ADDR_WIPER_90K: wiper_sel = TPW_SEL_90K;
         `TPW_ADDR_WIPER_10K_A: wiper_sel = TPW_SEL_10K_A;
         `TPW_ADDR_WIPER_10K_B: wiper_sel = TPW_SEL_10K_B;
         default: wiper_sel = TPW_SEL_NONE;
      endcase
   endfunction : wiper_sel

   // device address byte match, direction bit excluded
   function automatic logic addr_match(input logic [7:0] b, input logic s);
      addr_match = (b[7:1] == {`TPW_DEV_FIXED, s});
   endfunction : addr_match

   // byte returned by a read; unmapped addresses read zero
   function automatic logic [7:0] read_byte(input logic [7:0] a, input logic [2:0][6:0] w);
      tpw_sel_t s;
      s = wiper_sel(a);
      read_byte = (s == TPW_SEL_NONE) ? 8'h00 : {1'b0, w[s]};
   endfunction : read_byte

   always_comb
   begin
      next_state = state;
      next_after = after;
      next_cnt = cnt;
      next_shift = shift;
      next_tx = tx;
      next_oe = sda_oe;
      next_mem = mem_addr;
      next_pdata = pdata;
      next_pvalid = pvalid;
      next_wiper = wiper;
      store_go = 1'b0;
      ca = 8'h00;
      cs = TPW_SEL_NONE;
      rx_byte = {shift[6:0], sda_s};
      if (store_busy)
      begin
         // bus inputs are ignored while the store runs
         next_state = TPW_IDLE;
         next_oe = 1'b0;
      end
      else if (stop_ev)
      begin
         // the buffered page is committed only here
         for (int i = 0; i < `TPW_PAGE_BYTES; i++)
         begin
            ca = {mem_addr[7:3], 3'(i)};
            cs = wiper_sel(ca);
            if (pvalid[i] && !wp_s && cs != TPW_SEL_NONE)
               next_wiper[cs] = pdata[i][6:0];
         end
         store_go = (|pvalid) && !wp_s;
         next_pvalid = '0;
         next_state = TPW_IDLE;
         next_oe = 1'b0;
      end
      else if (start_ev)
      begin
         next_state = TPW_DEV_ADDR;
         next_cnt = 3'h0;
         next_oe = 1'b0;
         next_pvalid = '0;
      end
      else
      begin
         unique case (state)
            TPW_IDLE, TPW_IGNORE:
               next_oe = 1'b0;
            TPW_DEV_ADDR, TPW_MEM_ADDR, TPW_WR_DATA:
               if (scl_rise)
               begin
                  next_shift = rx_byte;
                  next_cnt = cnt + 3'h1;
                  if (cnt == `TPW_LAST_BIT)
                  begin
                     next_state = TPW_ACK_WAIT;
                     if (state == TPW_DEV_ADDR)
                     begin
                        if (!addr_match(rx_byte, strap_s))
                           next_state = TPW_IDLE;
                        next_after = rx_byte[0] ? TPW_RD_DATA : TPW_MEM_ADDR;
                     end
                     else if (state == TPW_MEM_ADDR)
                     begin
                        next_mem = rx_byte;
                        next_after = TPW_WR_DATA;
                     end
                     else
                     begin
                        next_pdata[mem_addr[2:0]] = rx_byte;
                        next_pvalid[mem_addr[2:0]] = 1'b1;
                        next_mem = {mem_addr[7:3], mem_addr[2:0] + 3'h1};
                        next_after = TPW_WR_DATA;
                     end
                  end
               end
            TPW_ACK_WAIT:
               if (scl_fall)
               begin
                  next_oe = 1'b1;
                  next_state = TPW_ACK;
               end
            TPW_ACK, TPW_RD_LOAD:
               if (scl_fall)
               begin
                  next_cnt = 3'h0;
                  if (state == TPW_RD_LOAD || after == TPW_RD_DATA)
                  begin
                     next_tx = read_byte(mem_addr, wiper);
                     next_oe = ~next_tx[7];
                     next_mem = mem_addr + 8'h01;
                     next_state = TPW_RD_DATA;
                  end
                  else
                  begin
                     next_oe = 1'b0;
                     next_state = after;
                  end
               end
            TPW_RD_DATA:
               if (scl_rise)
               begin
                  next_cnt = cnt + 3'h1;
                  if (cnt == `TPW_LAST_BIT)
                     next_state = TPW_RD_WAIT;
               end
               else if (scl_fall)
               begin
                  next_tx = {tx[6:0], 1'b0};
                  next_oe = ~tx[6];
               end
            TPW_RD_WAIT:
               if (scl_fall)
               begin
                  next_oe = 1'b0;
                  next_state = TPW_RD_ACK;
               end
            TPW_RD_ACK:
               if (scl_rise)
                  next_state = sda_s ? TPW_IGNORE : TPW_RD_LOAD;
         endcase
      end
      next_standby = (next_state == TPW_IDLE) && !store_busy && !store_go;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state <= TPW_IDLE;
         after <= TPW_MEM_ADDR;
         cnt <= 3'h0;
         shift <= 8'h00;
         tx <= 8'h00;
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
         mem_addr <= 8'h00;
         pdata <= '0;
         pvalid <= 8'h00;
         wiper <= {3{`TPW_WIPER_DEFAULT}};
         standby <= 1'b1;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         state <= next_state;
         after <= next_after;
         cnt <= next_cnt;
         shift <= next_shift;
         tx <= next_tx;
         sda_oe <= next_oe;
         sda_out <= 1'b0;
         mem_addr <= next_mem;
         pdata <= next_pdata;
         pvalid <= next_pvalid;
         wiper <= next_wiper;
         standby <= next_standby;
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // reset and write-protect checks
   wiper_reset_a: assert property ($fell(sys_rst) |-> wiper_90k == `TPW_WIPER_DEFAULT
      && wiper_10k_a == `TPW_WIPER_DEFAULT && wiper_10k_b == `TPW_WIPER_DEFAULT)
      else $error("wiper not at default after reset");
   wp_lock_a: assert property (wp_s |=> $stable(wiper))
      else $error("wiper changed while protected");
   // address and transfer checks
   addr_mismatch_a: assert property ((state == TPW_DEV_ADDR && scl_rise && cnt == `TPW_LAST_BIT
      && !store_busy && !addr_match(rx_byte, strap_s)) |=> state == TPW_IDLE)
      else $error("mismatched address not dropped");
   read_dir_a: assert property ((state == TPW_DEV_ADDR && scl_rise && cnt == `TPW_LAST_BIT
      && !store_busy && rx_byte[0]) |=> after == TPW_RD_DATA)
      else $error("read direction not taken");
   ack_drive_a: assert property ((state == TPW_ACK_WAIT && scl_fall && !store_busy) |=> sda_oe)
      else $error("acknowledge not driven");
   start_seen_a: assert property ((start_ev && !store_busy) |=> state == TPW_DEV_ADDR && cnt == 3'h0)
      else $error("start not detected");
   stop_seen_a: assert property (stop_ev |=> state == TPW_IDLE && !sda_oe)
      else $error("stop did not idle the slave");
   store_at_stop_a: assert property ($rose(store_busy) |-> $past(stop_ev))
      else $error("store began without a stop");
   busy_quiet_a: assert property (store_busy |=> !sda_oe && state == TPW_IDLE)
      else $error("bus answered during store");
   page_wrap_a: assert property ((state == TPW_WR_DATA && scl_rise && cnt == `TPW_LAST_BIT && !store_busy)
      |=> mem_addr[7:3] == $past(mem_addr[7:3]) && mem_addr[2:0] == $past(mem_addr[2:0]) + 3'h1)
      else $error("page address did not wrap");

   // acknowledge and release checks
   ack_hold_a: assert property ((state == TPW_ACK && !scl_fall && !start_ev && !stop_ev
      && !store_busy) |=> sda_oe)
      else $error("acknowledge released early");
   idle_quiet_a: assert property (state == TPW_IDLE |=> !sda_oe)
      else $error("idle slave drove the data line");
   read_release_a: assert property ((state == TPW_RD_WAIT && scl_fall && !store_busy) |=> !sda_oe)
      else $error("data line not released for master acknowledge");
   read_first_a: assert property ((state == TPW_ACK && after == TPW_RD_DATA && scl_fall && !store_busy)
      |=> state == TPW_RD_DATA && sda_oe == !tx[7])
      else $error("first read bit not driven");
   read_step_a: assert property ((state == TPW_RD_LOAD && scl_fall && !store_busy)
      |=> mem_addr == $past(mem_addr) + 8'h01)
      else $error("read pointer did not advance");

   // commit and store checks
   commit_only_a: assert property (!stop_ev |=> $stable(wiper))
      else $error("wiper changed away from a stop");
   commit_value_a: assert property ((stop_ev && !store_busy && !wp_s && pvalid[0]
      && {mem_addr[7:3], 3'h0} == `TPW_ADDR_WIPER_90K) |=> wiper_90k == $past(pdata[0][6:0]))
      else $error("committed wiper value wrong");
   protect_store_a: assert property ((stop_ev && wp_s && !store_busy) |=> !store_busy)
      else $error("protected write started a store");
   standby_idle_a: assert property (standby |-> state == TPW_IDLE && !store_busy)
      else $error("standby outside idle");
endmodule : tpw_slave

/* File: tpw_master.sv */
// two-wire bus master model that drives the serial clock
`timescale 1ns/1ps
module tpw_master (
   output logic scl, // serial clock
   output logic sda_low, // high pulls data low
   input wire logic sda // resolved data line
);
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic bit_io(input logic b, output logic s);
      scl = 1'b0;
      #31.25 sda_low = ~b;
      #31.25 scl = 1'b1;
      #31.25 s = sda;
      #31.25;
   endtask : bit_io
   task automatic start();
      scl = 1'b0;
      #31 sda_low = 1'b0;
      #31 scl = 1'b1;
      #62 sda_low = 1'b1;
      #62;
   endtask : start
   task automatic stop();
      scl = 1'b0;
      #31 sda_low = 1'b1;
      #31 scl = 1'b1;
      #62 sda_low = 1'b0;
      #62;
   endtask : stop
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask : wbyte
   task automatic rbyte(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(~more, s);
   endtask : rbyte
   // clock until data is seen high, then start while the clock is high
   task automatic recover();
      logic s;
      s = 1'b0;
      for (int i = 0; i < 9 && !s; i++)
         bit_io(1'b1, s);
      sda_low = 1'b1;
      #62;
   endtask : recover
endmodule : tpw_master

/* File: triple_pot_two_wire_slave_tb.sv */
// self-checking bench for the two-wire wiper slave
`timescale 1ns/1ps
module triple_pot_two_wire_slave_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic strap = 1'b0;
   logic wp = 1'b0;
   logic scl, sda_low, sda_out, sda_oe, busy, standby;
   logic [6:0] w90, w10a, w10b;
   logic [6:0] model [3];
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   wire sda = !(sda_low || (sda_oe && !sda_out));
   always #4 clk = ~clk;
   tpw_master m (.scl(scl), .sda_low(sda_low), .sda(sda));
   tpw_slave #(.STORE_CYCLES(50)) dut (.clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
      .address_select_strap(strap), .write_protect(wp), .sda_out(sda_out), .sda_oe(sda_oe),
      .wiper_90k(w90), .wiper_10k_a(w10a), .wiper_10k_b(w10b), .store_busy(busy), .standby(standby));
   function automatic logic [7:0] dev(input logic s, input logic rw);
      return {6'h28, s, rw};
   endfunction : dev
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      return (a >= 8'hF8 && a <= 8'hFA) ? {1'b0, model[a[1:0]]} : 8'h00;
   endfunction : exp_rd
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] want);
      n_compared++;
      if (seen !== want)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, want, seen);
      end
   endtask : chk
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   task automatic cw();
      chk("wiper_90k", {1'b0, w90}, {1'b0, model[0]});
      chk("wiper_10k_a", {1'b0, w10a}, {1'b0, model[1]});
      chk("wiper_10k_b", {1'b0, w10b}, {1'b0, model[2]});
   endtask : cw
   task automatic wait_busy(input logic lvl);
      for (int i = 0; i < 100 && busy !== lvl; i++)
         @(negedge clk);
      chk("store_busy", {7'h00, busy}, {7'h00, lvl});
   endtask : wait_busy
   task automatic set_pins(input logic p, input logic s);
      @(negedge clk);
      wp = p;
      strap = s;
      repeat (8) @(negedge clk);
   endtask : set_pins
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input int n);
      logic ak;
      logic [7:0] x;
      logic [6:0] nxt [3];
      nxt = model;
      m.start();
      m.wbyte(dev(strap, 1'b0), ak);
      chk("dev ack", {7'h00, ak}, 8'h01);
      m.wbyte(a, ak);
      chk("mem ack", {7'h00, ak}, 8'h01);
      for (int k = 0; k < n; k++)
      begin
         x = {a[7:3], 3'(a[2:0] + 3'(k))};
         m.wbyte(v + 8'(k), ak);
         chk("data ack", {7'h00, ak}, 8'h01);
         if (!wp && x >= 8'hF8 && x <= 8'hFA)
            nxt[x[1:0]] = 7'(v + 8'(k));
      end
      cw();
      chk("early busy", {7'h00, busy}, 8'h00);
      m.stop();
      if (!wp)
      begin
         wait_busy(1'b1);
         m.start();
         m.wbyte(dev(strap, 1'b0), ak);
         chk("busy ack", {7'h00, ak}, 8'h00);
         m.stop();
         wait_busy(1'b0);
      end
      model = nxt;
      repeat (4) @(negedge clk);
      cw();
      chk("standby", {7'h00, standby}, 8'h01);
   endtask : wr
   task automatic rd(input logic [7:0] a, input int n);
      logic ak;
      logic [7:0] d;
      m.start();
      m.wbyte(dev(strap, 1'b0), ak);
      m.wbyte(a, ak);
      m.start();
      m.wbyte(dev(strap, 1'b1), ak);
      chk("read ack", {7'h00, ak}, 8'h01);
      for (int k = 0; k < n; k++)
      begin
         m.rbyte(k < n - 1, d);
         chk("read data", d, exp_rd(a + 8'(k)));
      end
      m.stop();
      repeat (4) @(negedge clk);
      chk("standby", {7'h00, standby}, 8'h01);
   endtask : rd
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         n_mismatch++;
         wrap_up();
      end
   end
   initial
   begin
      logic ak;
      logic [7:0] v;
      logic [7:0] e;
      model = '{7'h7F, 7'h7F, 7'h7F};
      void'($urandom(32'hB724));
      repeat (5) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      set_pins(1'b0, 1'($urandom));
      cw();
      chk("standby", {7'h00, standby}, 8'h01);
      for (int i = 0; i < 3; i++)
         wr(8'hF8 + 8'(i), (i == 0) ? 8'hFF : 8'($urandom), 1);
      rd(8'hF8, 4);
      set_pins(1'b1, strap);
      wr(8'hF9, 8'($urandom), 1);
      set_pins(1'b0, strap);
      wr(8'hFE, 8'($urandom), 4);
      rd(8'hF7, 3);
      m.start();
      m.wbyte(dev(~strap, 1'b0), ak);
      chk("foreign ack", {7'h00, ak}, 8'h00);
      chk("standby", {7'h00, standby}, 8'h01);
      m.stop();
      // abort a read in mid-byte, then recover the bus
      m.start();
      m.wbyte(dev(strap, 1'b1), ak);
      for (int i = 0; i < 3; i++)
         m.bit_io(1'b1, v[i]);
      e = exp_rd(8'hFA);
      chk("aborted read", {5'h00, v[0], v[1], v[2]}, {5'h00, e[7:5]});
      m.recover();
      m.stop();
      rd(8'hFA, 1);
      repeat (4)
      begin
         set_pins(1'($urandom), 1'($urandom));
         wr(8'hF8 + 8'($urandom % 3), 8'($urandom), 1 + int'($urandom % 3));
         rd(8'hF8, 3);
      end
      wrap_up();
   end
endmodule : triple_pot_two_wire_slave_tb
